/* File: bench/ebr_host_model.sv */
// far-side host port model
`timescale 1ns/1ps
module ebr_host_model (
	input wire logic host_data_strobe_low,
	input wire logic [15:0] word,
	input wire logic stall,
	output logic [15:0] bus_in,
	output logic host_wait_line
);
	// word only under the strobe; inverse otherwise so a stale sample never matches
	assign bus_in = host_data_strobe_low ? ~word : word;
	// wait raised whenever the bench commands it
	assign host_wait_line = stall;
endmodule

/* File: bench/ebr_mux_read_assertions.sv */
// port checker for the read sequencer
`timescale 1ns/1ps
module ebr_mux_read_assertions (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic req_ready,
	input wire logic rd_valid,
	input wire logic cfg_error,
	input wire logic busy,
	input wire logic chip_select_low,
	input wire logic host_data_strobe_low,
	input wire logic bus_oe,
	input wire logic host_wait_line
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	// minimum settings give five select cycles and two strobe cycles
	property p_addr; $fell(chip_select_low) |-> bus_oe; endproperty
	a_addr: assert property (p_addr) else $error("no address at select");
	property p_s2s; $fell(chip_select_low) |-> host_data_strobe_low[*5]; endproperty
	a_s2s: assert property (p_s2s) else $error("strobe too early");
	property p_pw; $fell(host_data_strobe_low) |-> !host_data_strobe_low[*2]; endproperty
	a_pw: assert property (p_pw) else $error("strobe too short");
	property p_cap; $rose(host_data_strobe_low) |-> rd_valid && chip_select_low; endproperty
	a_cap: assert property (p_cap) else $error("no data at strobe end");
	property p_one; rd_valid |=> !rd_valid; endproperty
	a_one: assert property (p_one) else $error("valid too long");
	property p_rec; $rose(chip_select_low) |-> chip_select_low[*2]; endproperty
	a_rec: assert property (p_rec) else $error("recovery too short");
	property p_wt; host_wait_line && !host_data_strobe_low |=> !host_data_strobe_low; endproperty
	a_wt: assert property (p_wt) else $error("left strobe under wait");
	property p_ext;
		$fell(host_wait_line) && !host_data_strobe_low |=> !host_data_strobe_low;
	endproperty
	a_ext: assert property (p_ext) else $error("strobe ended at wait release");
	property p_free; !host_data_strobe_low |-> !bus_oe && !chip_select_low; endproperty
	a_free: assert property (p_free) else $error("bus driven in strobe");
	property p_ref; busy || cfg_error |-> !req_ready; endproperty
	a_ref: assert property (p_ref) else $error("ready while refused");
	c_rd: cover property (rd_valid);
	c_wt: cover property (host_wait_line && !host_data_strobe_low);
	c_cfg: cover property (cfg_error);
endmodule
bind ebr_mux_read ebr_mux_read_assertions u_chk (.mclk(mclk), .resetn(resetn),
	.req_ready(req_ready), .rd_valid(rd_valid), .cfg_error(cfg_error), .busy(busy),
	.chip_select_low(chip_select_low), .host_data_strobe_low(host_data_strobe_low),
	.bus_oe(bus_oe), .host_wait_line(host_wait_line));

/* File: bench/test_ebr_mux_read.sv */
// self-checking bench for the read sequencer
`timescale 1ns/1ps
module test_ebr_mux_read;
	logic mclk, resetn, req_valid, stall, req_ready, rd_valid, cfg_error, busy;
	logic chip_select_low, host_data_strobe_low, bus_oe, host_wait_line;
	logic [15:0] req_addr, word, bus_in, rd_data, bus_out;
	logic [15:0] bad [3] = '{16'h1111, 16'h1201, 16'h0211};
	ebr_pkg::ebr_timing_s timing;
	int n_errors, checked, n;
	ebr_mux_read u_dut (.mclk(mclk), .resetn(resetn), .ce(1'b1), .timing(timing),
		.req_valid(req_valid), .req_addr(req_addr), .req_ready(req_ready), .rd_data(rd_data),
		.rd_valid(rd_valid), .cfg_error(cfg_error), .busy(busy), .bus_out(bus_out),
		.chip_select_low(chip_select_low), .host_data_strobe_low(host_data_strobe_low),
		.bus_oe(bus_oe), .bus_in(bus_in), .host_wait_line(host_wait_line));
	ebr_host_model u_host (.host_data_strobe_low(host_data_strobe_low), .word(word),
		.stall(stall), .bus_in(bus_in), .host_wait_line(host_wait_line));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run;
		if (n_errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one read; wa and ws are wait cycles forced at address and strobe phase start
	task automatic rd(input logic [15:0] t, a, d, input int wa, ws);
		int c;
		timing = t;
		req_addr = a;
		word = d;
		req_valid = 1'b1;
		#1;
		chk("ready", {15'h0, req_ready}, 16'h0001);
		@(negedge mclk);
		req_valid = 1'b0;
		for (c = 0; chip_select_low && c < 4; c++) @(negedge mclk);
		chk("addr", bus_out, a);
		stall = (wa != 0);
		for (c = 1; host_data_strobe_low && c < 90; c += host_data_strobe_low) begin
			@(negedge mclk);
			if (c == wa) stall = 1'b0;
		end
		chk("select_to_strobe", 16'(c), 16'(t[15:12] + t[11:8] + 2 + wa));
		stall = (ws != 0);
		for (c = 1; !host_data_strobe_low && c < 90; c += !host_data_strobe_low) begin
			@(negedge mclk);
			if (c == ws) stall = 1'b0;
		end
		chk("strobe_width", 16'(c), 16'(t[7:4] + 1 + ws));
		chk("data", rd_data, d);
		chk("valid", {15'h0, rd_valid}, 16'h0001);
		for (c = 0; !req_ready && c < 40; c++) @(negedge mclk);
		chk("recovery", 16'(c), 16'(t[3:0] + 1));
	endtask
	// 25 MHz clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// watchdog far beyond the roughly 140 cycles the sequence needs
	initial begin
		#400000;
		n_errors++;
		complete_run();
	end
	// main sequence: inputs change on falling edges
	initial begin
		{n_errors, checked, resetn, req_valid, stall, req_addr, word} = '0;
		timing = 16'h1211;
		repeat (2) @(negedge mclk);
		chk("reset", {12'h0, chip_select_low, host_data_strobe_low, bus_oe, rd_valid}, 16'h000C);
		resetn = 1'b1;
		rd(16'h1210, 16'hA55A, 16'h3CC3, 0, 0);
		rd(16'h121F, 16'h0001, 16'hFFFE, 0, 0);
		rd(16'h3427, 16'h8000, 16'h1234, 3, 2);
		rd(16'hFFF5, 16'h7FFF, 16'hC001, 1, 1);
		// wait raised only in the last strobe cycle: strobe runs 2 + 1 held + 1 extra
		timing = 16'h1211;
		word = 16'h5AA5;
		req_valid = 1'b1;
		@(negedge mclk);
		req_valid = 1'b0;
		for (n = 0; host_data_strobe_low && n < 90; n++) @(negedge mclk);
		@(negedge mclk);
		stall = 1'b1;
		@(negedge mclk);
		stall = 1'b0;
		for (n = 2; !host_data_strobe_low && n < 90; n++) @(negedge mclk);
		chk("strobe_extended", 16'(n), 16'h0004);
		chk("data_extended", rd_data, 16'h5AA5);
		// illegal settings are refused, never started
		foreach (bad[i]) begin
			timing = bad[i];
			req_valid = 1'b1;
			repeat (3) @(negedge mclk);
			chk("refused", {14'h0, cfg_error, chip_select_low}, 16'h0003);
		end
		complete_run();
	end
endmodule

/* File: common/ebr_pkg.sv */
// package: phase settings, limits and carriers for the multiplexed host-port read sequencer
package ebr_pkg;
	localparam int ADDR_W = 16;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] ADDR_PHASE_RST = 4'h1;
	localparam logic [CNT_W-1:0] SETUP_PHASE_RST = 4'h2;
	localparam logic [CNT_W-1:0] STROBE_PHASE_RST = 4'h3;
	localparam logic [CNT_W-1:0] RECOV_PHASE_RST = 4'h1;
	localparam logic [CNT_W-1:0] MIN_SETUP_SETTING = 4'h2;
	localparam logic [CNT_W-1:0] MIN_STROBE_SETTING = 4'h1;
	localparam logic [CNT_W-1:0] MIN_ADDR_SETTING = 4'h1;
	localparam int ADDR_VALID_MAX_CYC = 45;
	localparam int SELECT_TO_STROBE_MIN_CYC = 3;
	localparam int STROBE_PULSE_MIN_CYC = 4;
	localparam int STROBE_PULSE_MAX_CYC = 5;
	localparam int RECOV_MIN_CYC = 2;
	localparam int RECOV_MAX_CYC = 17;
	localparam logic [ADDR_W-1:0] DATA_RST = 16'h0000;

	// phase lengths as software sets them; each phase lasts setting+1 cycles
	typedef struct packed {
		logic [CNT_W-1:0] address_phase_count;
		logic [CNT_W-1:0] setup_phase_count;
		logic [CNT_W-1:0] strobe_phase_count;
		logic [CNT_W-1:0] recovery_phase_count;
	} ebr_timing_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_SETUP,
		ST_STROBE,
		ST_RECOV
	} ebr_state_e;
endpackage

/* File: core/ebr_mux_read.sv */
// multiplexed host-port read sequencer: address, setup, strobe and recovery phases
`timescale 1ns/1ps
module ebr_mux_read #(
	parameter int ADDR_W = ebr_pkg::ADDR_W,
	parameter int CNT_W = ebr_pkg::CNT_W
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire ebr_pkg::ebr_timing_s timing,
	input wire logic req_valid,
	input wire logic [ADDR_W-1:0] req_addr,
	output logic req_ready,
	output logic [ADDR_W-1:0] rd_data,
	output logic rd_valid,
	output logic cfg_error,
	output logic busy,
	output logic chip_select_low,
	output logic host_data_strobe_low,
	output logic [ADDR_W-1:0] bus_out,
	output logic bus_oe,
	input wire logic [ADDR_W-1:0] bus_in,
	input wire logic host_wait_line
);
	////////////////////////////////////////////////////////////////////////////
	// elaboration checks: the struct carrier fixes both widths
	if (ADDR_W != ebr_pkg::ADDR_W) begin : g_addr_w_check
		$error("ebr_mux_read: bus must be 16 bits wide");
	end
	if (CNT_W != ebr_pkg::CNT_W) begin : g_cnt_w_check
		$error("ebr_mux_read: phase counter width must match the package");
	end

	// sequencer state, latched request, captured data and pin flops
	ebr_pkg::ebr_state_e state_q;
	ebr_pkg::ebr_state_e state_d;
	ebr_pkg::ebr_timing_s tim_q;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] data_q;
	logic rd_valid_q;
	logic cs_low_q;
	logic ds_low_q;
	logic oe_q;
	logic wait_seen_q;
	logic cnt_load;
	logic [CNT_W-1:0] cnt_val;
	logic cnt_hold;
	logic cnt_done;
	logic phase_end;

	// setting is too small for the wait line to be recognised in time
	function automatic logic setting_bad(input ebr_pkg::ebr_timing_s t);
		setting_bad = (t.address_phase_count < ebr_pkg::MIN_ADDR_SETTING)
			|| (t.setup_phase_count < ebr_pkg::MIN_SETUP_SETTING)
			|| (t.strobe_phase_count < ebr_pkg::MIN_STROBE_SETTING);
	endfunction

	// waiting only matters in the address and strobe phases
	function automatic logic stall_phase(input ebr_pkg::ebr_state_e s);
		stall_phase = (s == ebr_pkg::ST_ADDR) || (s == ebr_pkg::ST_STROBE);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// a phase stalled after its count has run out gets one extra cycle after the wait line is released
	assign cnt_hold = stall_phase(state_q) && host_wait_line;
	assign phase_end = cnt_done && !wait_seen_q;
	assign req_ready = (state_q == ebr_pkg::ST_IDLE) && !setting_bad(timing);
	assign busy = state_q != ebr_pkg::ST_IDLE;
	assign cfg_error = setting_bad(timing);

	// one shared down-counter times every phase; a wait in the address or strobe phase freezes it
	ebr_phase_cnt #(
		.W(CNT_W)
	) u_cnt (
		.mclk(mclk),
		.resetn(resetn),
		.ce(ce),
		.load(cnt_load),
		.load_val(cnt_val),
		.hold(cnt_hold),
		.done(cnt_done)
	);

	////////////////////////////////////////////////////////////////////////////
	// next state and counter load; all counts are mclk cycles
	always_comb begin
		state_d = state_q;
		cnt_load = 1'b0;
		cnt_val = '0;
		case (state_q)
			ebr_pkg::ST_IDLE: begin
				if (req_valid && req_ready) begin
					state_d = ebr_pkg::ST_ADDR;
					cnt_load = 1'b1;
					cnt_val = timing.address_phase_count;
				end
			end
			ebr_pkg::ST_ADDR: begin
				if (phase_end) begin
					state_d = ebr_pkg::ST_SETUP;
					cnt_load = 1'b1;
					cnt_val = tim_q.setup_phase_count;
				end
			end
			ebr_pkg::ST_SETUP: begin
				if (phase_end) begin
					state_d = ebr_pkg::ST_STROBE;
					cnt_load = 1'b1;
					cnt_val = tim_q.strobe_phase_count;
				end
			end
			ebr_pkg::ST_STROBE: begin
				if (phase_end) begin
					state_d = ebr_pkg::ST_RECOV;
					cnt_load = 1'b1;
					cnt_val = tim_q.recovery_phase_count;
				end
			end
			ebr_pkg::ST_RECOV: begin
				// no wait handling here: the far side only stalls address and strobe
				if (phase_end) begin
					state_d = ebr_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = ebr_pkg::ST_IDLE;
			end
		endcase
	end

	// state register; ce low freezes it with the rest
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_q <= ebr_pkg::ST_IDLE;
		end else if (ce) begin
			state_q <= state_d;
		end
	end

	// remember a wait seen in this phase; the first clear cycle is the extra one
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wait_seen_q <= 1'b0;
		end else if (ce) begin
			if (cnt_load) begin
				wait_seen_q <= 1'b0;
			end else if (stall_phase(state_q)) begin
				wait_seen_q <= host_wait_line;
			end
		end
	end

	// timing and address latched at request so mid-access changes do no harm
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			tim_q <= {ebr_pkg::ADDR_PHASE_RST, ebr_pkg::SETUP_PHASE_RST,
				ebr_pkg::STROBE_PHASE_RST, ebr_pkg::RECOV_PHASE_RST};
			addr_q <= ebr_pkg::DATA_RST;
		end else if (ce && state_q == ebr_pkg::ST_IDLE && req_valid && req_ready) begin
			tim_q <= timing;
			addr_q <= req_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin drive: select with address together, strobe only in the strobe phase
	// registered from state_d so select, address and strobe move on one edge
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cs_low_q <= 1'b1;
			ds_low_q <= 1'b1;
			oe_q <= 1'b0;
		end else if (ce) begin
			cs_low_q <= !(state_d == ebr_pkg::ST_ADDR || state_d == ebr_pkg::ST_SETUP
				|| state_d == ebr_pkg::ST_STROBE);
			oe_q <= state_d == ebr_pkg::ST_ADDR || state_d == ebr_pkg::ST_SETUP;
			ds_low_q <= !(state_d == ebr_pkg::ST_STROBE);
		end
	end

	// bus released on the edge the strobe falls so the host port can drive read data
	assign bus_out = addr_q;

	// capture on the last strobe cycle, while strobe and select are still low
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			data_q <= ebr_pkg::DATA_RST;
			rd_valid_q <= 1'b0;
		end else if (ce) begin
			rd_valid_q <= 1'b0;
			if (state_q == ebr_pkg::ST_STROBE && phase_end) begin
				data_q <= bus_in;
				rd_valid_q <= 1'b1;
			end
		end
	end

	// outputs straight from their flops
	assign rd_data = data_q;
	assign rd_valid = rd_valid_q;
	assign chip_select_low = cs_low_q;
	assign host_data_strobe_low = ds_low_q;
	assign bus_oe = oe_q;
endmodule

/* File: core/ebr_phase_cnt.sv */
// phase down-counter with load, hold and expiry flag
`timescale 1ns/1ps
module ebr_phase_cnt #(
	parameter int W = 4
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic hold,
	output logic done
);
	logic [W-1:0] cnt_q;

	// elaboration check: a one-bit counter cannot hold the minimum settings
	if (W < 2) begin : g_w_check
		$error("ebr_phase_cnt: W must be at least 2");
	end

	// count freezes while hold is high so a stalled phase never expires
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			cnt_q <= '0;
		end else if (ce) begin
			if (load) begin
				cnt_q <= load_val;
			end else if (!hold && cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

	// load is decoded from done upstream, so done must not read it back (zero-delay loop)
	assign done = (cnt_q == '0) && !hold;
endmodule
